//--- src/atic_consts.vh
// Purpose: shared constants of the actuator teach-in controller
// Assumes: 200 MHz core clock; all times held in milliseconds
// Notes: cycle counts are 40 bits wide because the readiness window exceeds 2^32 cycles
`ifndef ATIC_CONSTS_VH
`define ATIC_CONSTS_VH

`define ATIC_CODE_W 32
`define ATIC_CYC_PER_MS 40'h0000030D40

// times as printed, in milliseconds
`define ATIC_RST_HOLD_MS 40'h0000000BB8
`define ATIC_INIT_MS 40'h0000002710
`define ATIC_READY_MS 40'h000002BF20
`define ATIC_TEACH_MS 40'h0000007530
`define ATIC_FAST_HALF_MS 40'h0000000064
`define ATIC_SLOW_HALF_MS 40'h00000001F4
`define ATIC_BURST_HALF_MS 40'h000000007D

// derived cycle counts (exact multiples, so no rounding needed)
`define ATIC_RST_HOLD_CYC (`ATIC_RST_HOLD_MS * `ATIC_CYC_PER_MS)
`define ATIC_INIT_CYC (`ATIC_INIT_MS * `ATIC_CYC_PER_MS)
`define ATIC_READY_CYC (`ATIC_READY_MS * `ATIC_CYC_PER_MS)
`define ATIC_TEACH_CYC (`ATIC_TEACH_MS * `ATIC_CYC_PER_MS)
`define ATIC_FAST_HALF_CYC (`ATIC_FAST_HALF_MS * `ATIC_CYC_PER_MS)
`define ATIC_SLOW_HALF_CYC (`ATIC_SLOW_HALF_MS * `ATIC_CYC_PER_MS)
`define ATIC_BURST_HALF_CYC (`ATIC_BURST_HALF_MS * `ATIC_CYC_PER_MS)

// flash bursts: flashes per burst, and burst length incl. two dark slots
`define ATIC_BURST_READY 3'h3
`define ATIC_BURST_TEACH_ERR 3'h1
`define ATIC_BURST_BLOCKED 3'h5
`define ATIC_BURST_GAP 3'h2

`endif

//--- src/atic_square_gen.v
// Purpose: free-running square wave with a programmable half period
// Assumes: i_core_clk at 200 MHz, HALF at least 1
// Notes: o_fall pulses one cycle when the wave drops, used to count flashes
`timescale 1ns/1ps
module atic_square_gen #(
  parameter [39:0] HALF = 40'h0000000001
) (
  input wire i_core_clk,
  input wire i_nrst,
  output reg o_wave,
  output reg o_fall
);

  reg [39:0] cnt;

  // toggle every HALF cycles
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt <= 40'h0000000000;
      o_wave <= 1'b0;
      o_fall <= 1'b0;
    end else if (cnt >= HALF - 40'h0000000001) begin
      cnt <= 40'h0000000000;
      o_wave <= ~o_wave;
      o_fall <= o_wave;
    end else begin
      cnt <= cnt + 40'h0000000001;
      o_fall <= 1'b0;
    end
  end

endmodule // atic_square_gen

//--- src/atic_teach_ctrl.v
// Purpose: power-up, teach-in and code acceptance control of a coded locking switch
// Assumes: actuator reader and non-volatile store run on i_core_clk; pins are asynchronous
// Notes: the code store itself lives outside; this block reads its image and writes it back
//
// Behaviour
// - chain reset held high three seconds restarts the switch; shorter pulses ignored; the code drops the restart if it meets a valid code in readiness
// - after power-on initialise with safe outputs off and status lamp at 5 Hz
// - only the most recently activated actuator code enables the safe outputs
// - safe outputs stay off during any teach-in operation
// - never-taught switch stays ready for teach-in without timeout
// - aborted teach-in is discarded; error with diagnostic lamp on, status flashing
// - readiness shown by repeated bursts of three status flashes
// - actuator in readiness starts 1 Hz teach; after 30 s lamps alternate
// - new code activates only at the next restart (power-on or chain reset); operator cycles supply
// - a switch with a taught code opens a three minute readiness window
// - detecting the already taught actuator cancels teach-in, back to normal
// - blocked predecessor code cancels teach-in, keeps current code, enters error
// - new teach blocks the previous code until a third code is taught
// - in a chain a three second reset pulse starts teach; a second activates
// - lock input high is an active lock command on power-to-lock variants
`timescale 1ns/1ps
`include "atic_consts.vh"
module atic_teach_ctrl #(
  parameter [39:0] RST_HOLD_CYC = `ATIC_RST_HOLD_CYC,
  parameter [39:0] INIT_CYC = `ATIC_INIT_CYC,
  parameter [39:0] READY_CYC = `ATIC_READY_CYC,
  parameter [39:0] TEACH_CYC = `ATIC_TEACH_CYC,
  parameter [39:0] FAST_HALF_CYC = `ATIC_FAST_HALF_CYC,
  parameter [39:0] SLOW_HALF_CYC = `ATIC_SLOW_HALF_CYC,
  parameter [39:0] BURST_HALF_CYC = `ATIC_BURST_HALF_CYC
) (
  input wire i_core_clk,
  input wire i_nrst,
  input wire i_chain_reset,
  input wire i_lock_input,
  input wire i_enable_one,
  input wire i_enable_two,
  input wire i_code_valid,
  input wire [`ATIC_CODE_W-1:0] i_actuator_code,
  input wire i_nv_active_valid,
  input wire [`ATIC_CODE_W-1:0] i_nv_active_code,
  input wire i_nv_blocked_valid,
  input wire [`ATIC_CODE_W-1:0] i_nv_blocked_code,
  input wire i_nv_pending_valid,
  input wire [`ATIC_CODE_W-1:0] i_nv_pending_code,
  input wire i_nv_busy,
  output reg o_safe_output_one,
  output reg o_safe_output_two,
  output reg o_status_lamp,
  output reg o_diagnostic_lamp,
  output reg o_lock_drive,
  output reg [2:0] o_state,
  output reg o_nv_wr,
  output reg o_nv_active_valid,
  output reg [`ATIC_CODE_W-1:0] o_nv_active_code,
  output reg o_nv_blocked_valid,
  output reg [`ATIC_CODE_W-1:0] o_nv_blocked_code,
  output reg o_nv_pending_valid,
  output reg [`ATIC_CODE_W-1:0] o_nv_pending_code,
  output reg o_nv_busy
);

  localparam [2:0] ST_LOAD = 3'h0;
  localparam [2:0] ST_INIT = 3'h1;
  localparam [2:0] ST_READY = 3'h2;
  localparam [2:0] ST_TEACH = 3'h3;
  localparam [2:0] ST_DONE = 3'h4;
  localparam [2:0] ST_NORMAL = 3'h5;
  localparam [2:0] ST_ERR_TEACH = 3'h6;
  localparam [2:0] ST_ERR_BLOCKED = 3'h7;

  // two-stage synchronisers for the pins
  reg [3:0] sync_a;
  reg [3:0] sync_b;
  wire rst_pin = sync_b[0];
  wire lock_pin = sync_b[1];
  wire en1_pin = sync_b[2];
  wire en2_pin = sync_b[3];

  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
    end else begin
      sync_a <= {i_enable_two, i_enable_one, i_lock_input, i_chain_reset};
      sync_b <= sync_a;
    end
  end

  // chain reset hold filter: one event per high phase, only after the full hold time
  reg [39:0] rst_cnt;
  reg rst_fired;
  reg rst_event;

  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_cnt <= 40'h0000000000;
      rst_fired <= 1'b0;
      rst_event <= 1'b0;
    end else if (!rst_pin) begin
      rst_cnt <= 40'h0000000000;
      rst_fired <= 1'b0;
      rst_event <= 1'b0;
    end else if (!rst_fired && rst_cnt >= RST_HOLD_CYC - 40'h0000000001) begin
      rst_fired <= 1'b1;
      rst_event <= 1'b1;
    end else begin
      if (!rst_fired) begin
        rst_cnt <= rst_cnt + 40'h0000000001;
      end
      rst_event <= 1'b0;
    end
  end

  // lamp waveforms
  wire fast_wave;
  wire slow_wave;
  wire burst_wave;
  wire burst_fall;

  atic_square_gen #(.HALF(FAST_HALF_CYC)) u_fast (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .o_wave(fast_wave),
    .o_fall()
  );

  atic_square_gen #(.HALF(SLOW_HALF_CYC)) u_slow (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .o_wave(slow_wave),
    .o_fall()
  );

  atic_square_gen #(.HALF(BURST_HALF_CYC)) u_burst (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .o_wave(burst_wave),
    .o_fall(burst_fall)
  );

  reg [2:0] state;
  reg [39:0] timer;
  reg [2:0] burst_cnt;
  reg [2:0] burst_n;

  // flashes per burst by state; zero means no burst display
  always @* begin
    case (state)
      ST_READY: burst_n = `ATIC_BURST_READY;
      ST_ERR_TEACH: burst_n = `ATIC_BURST_TEACH_ERR;
      ST_ERR_BLOCKED: burst_n = `ATIC_BURST_BLOCKED;
      default: burst_n = 3'h0;
    endcase
  end

  // flash slot counter; the burst ends with two dark slots
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      burst_cnt <= 3'h0;
    end else if (burst_n == 3'h0) begin
      burst_cnt <= 3'h0;
    end else if (burst_fall) begin
      if (burst_cnt >= burst_n + `ATIC_BURST_GAP - 3'h1) begin
        burst_cnt <= 3'h0;
      end else begin
        burst_cnt <= burst_cnt + 3'h1;
      end
    end
  end

  wire burst_lamp = burst_wave & (burst_cnt < burst_n);
  wire code_is_active = o_nv_active_valid & (i_actuator_code == o_nv_active_code);
  wire code_is_blocked = o_nv_blocked_valid & (i_actuator_code == o_nv_blocked_code);
  wire timer_done_teach = (timer >= TEACH_CYC - 40'h0000000001);

  // main sequencer; the store image is held in the o_nv_* registers
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= ST_LOAD;
      timer <= 40'h0000000000;
      o_nv_wr <= 1'b0;
      o_nv_active_valid <= 1'b0;
      o_nv_active_code <= {`ATIC_CODE_W{1'b0}};
      o_nv_blocked_valid <= 1'b0;
      o_nv_blocked_code <= {`ATIC_CODE_W{1'b0}};
      o_nv_pending_valid <= 1'b0;
      o_nv_pending_code <= {`ATIC_CODE_W{1'b0}};
      o_nv_busy <= 1'b0;
    end else if (rst_event && !(state == ST_READY && i_code_valid)) begin
      state <= ST_LOAD;
      timer <= 40'h0000000000;
      o_nv_wr <= 1'b0;
    end else begin
      o_nv_wr <= 1'b0;
      timer <= timer + 40'h0000000001;
      case (state)
        ST_LOAD: begin
          // a pending code is promoted only at a fresh start
          timer <= 40'h0000000000;
          state <= ST_INIT;
          o_nv_busy <= 1'b0;
          o_nv_wr <= i_nv_pending_valid | i_nv_busy;
          o_nv_pending_valid <= 1'b0;
          o_nv_pending_code <= i_nv_pending_code;
          if (i_nv_pending_valid) begin
            o_nv_active_valid <= 1'b1;
            o_nv_active_code <= i_nv_pending_code;
            o_nv_blocked_valid <= i_nv_active_valid;
            o_nv_blocked_code <= i_nv_active_code;
          end else begin
            o_nv_active_valid <= i_nv_active_valid;
            o_nv_active_code <= i_nv_active_code;
            o_nv_blocked_valid <= i_nv_blocked_valid;
            o_nv_blocked_code <= i_nv_blocked_code;
          end
          if (i_nv_busy) begin
            state <= ST_ERR_TEACH;
          end
        end
        ST_INIT: begin
          if (timer >= INIT_CYC - 40'h0000000001) begin
            state <= ST_READY;
            timer <= 40'h0000000000;
          end
        end
        ST_READY: begin
          if (i_code_valid) begin
            timer <= 40'h0000000000;
            if (code_is_active) begin
              state <= ST_NORMAL;
            end else if (code_is_blocked) begin
              state <= ST_ERR_BLOCKED;
            end else begin
              state <= ST_TEACH;
              o_nv_busy <= 1'b1;
              o_nv_pending_code <= i_actuator_code;
              o_nv_wr <= 1'b1;
            end
          end else if (o_nv_active_valid && timer >= READY_CYC - 40'h0000000001) begin
            state <= ST_NORMAL;
          end else if (!o_nv_active_valid) begin
            timer <= 40'h0000000000;
          end
        end
        ST_TEACH: begin
          if (!i_code_valid || i_actuator_code != o_nv_pending_code) begin
            state <= ST_ERR_TEACH;
            o_nv_busy <= 1'b0;
            o_nv_pending_valid <= 1'b0;
            o_nv_wr <= 1'b1;
          end else if (timer_done_teach) begin
            state <= ST_DONE;
            o_nv_busy <= 1'b0;
            o_nv_pending_valid <= 1'b1;
            o_nv_wr <= 1'b1;
          end
        end
        ST_DONE: begin
          timer <= 40'h0000000000; // waits for a power cycle or chain reset
        end
        ST_NORMAL: begin
          timer <= 40'h0000000000;
        end
        ST_ERR_TEACH: begin
          timer <= 40'h0000000000;
        end
        ST_ERR_BLOCKED: begin
          timer <= 40'h0000000000;
        end
        default: begin
          state <= ST_LOAD;
        end
      endcase
    end
  end

  // outputs; each safe output needs the active code, its own enable and the lock command
  wire release_ok = (state == ST_NORMAL) & i_code_valid & code_is_active & lock_pin;

  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_safe_output_one <= 1'b0;
      o_safe_output_two <= 1'b0;
      o_status_lamp <= 1'b0;
      o_diagnostic_lamp <= 1'b0;
      o_lock_drive <= 1'b0;
      o_state <= ST_LOAD;
    end else begin
      o_state <= state;
      // teach states never reach ST_NORMAL, so outputs stay off there
      o_safe_output_one <= release_ok & en1_pin;
      o_safe_output_two <= release_ok & en2_pin;
      o_lock_drive <= lock_pin & (state == ST_NORMAL);
      case (state)
        ST_INIT: begin
          o_status_lamp <= fast_wave;
          o_diagnostic_lamp <= 1'b0;
        end
        ST_READY: begin
          o_status_lamp <= burst_lamp;
          o_diagnostic_lamp <= 1'b0;
        end
        ST_TEACH: begin
          o_status_lamp <= slow_wave;
          o_diagnostic_lamp <= 1'b0;
        end
        ST_DONE: begin
          o_status_lamp <= slow_wave;
          o_diagnostic_lamp <= ~slow_wave;
        end
        ST_NORMAL: begin
          o_status_lamp <= release_ok;
          o_diagnostic_lamp <= 1'b0;
        end
        ST_ERR_TEACH: begin
          o_status_lamp <= burst_lamp;
          o_diagnostic_lamp <= 1'b1;
        end
        ST_ERR_BLOCKED: begin
          o_status_lamp <= burst_lamp;
          o_diagnostic_lamp <= 1'b1;
        end
        default: begin
          o_status_lamp <= 1'b0;
          o_diagnostic_lamp <= 1'b0;
        end
      endcase
    end
  end

endmodule // atic_teach_ctrl

//--- verif/atic_nv_store.sv
// Purpose: non-volatile code store model on the far side of the controller
// Assumes: the image is written whole on a one-cycle write pulse
// Notes: no reset input, so the image outlives every restart; starts blank
`timescale 1ns/1ps
module atic_nv_store (
  input wire i_core_clk,
  input wire i_wr,
  input wire [99:0] i_img,
  output reg [99:0] o_img
);
  // blank image stands for a switch in delivery condition
  initial o_img = 100'h0;
  // keep the last written image through resets and supply loss
  always @(posedge i_core_clk) begin
    if (i_wr) begin
      o_img <= i_img;
    end
  end
endmodule // atic_nv_store

//--- verif/atic_teach_ctrl_assertions.sv
// Purpose: port-level checks of the teach-in controller
// Assumes: one clock domain, asynchronous active-low reset
// Notes: helper counters saturate at 255, enough for the shortened counts
`timescale 1ns/1ps
module atic_teach_ctrl_assertions #(
  parameter [39:0] RST_HOLD_CYC = 40'h14,
  parameter [39:0] READY_CYC = 40'h32,
  parameter [39:0] TEACH_CYC = 40'h1E
) (
  input wire i_core_clk,
  input wire i_nrst,
  input wire i_chain_reset,
  input wire i_code_valid,
  input wire i_nv_active_valid,
  input wire o_safe_output_one,
  input wire o_safe_output_two,
  input wire o_status_lamp,
  input wire o_diagnostic_lamp,
  input wire [2:0] o_state
);
  localparam int RMAX = READY_CYC[31:0] + 32'h00000004;
  reg [7:0] hi_cnt;
  reg [7:0] t_cnt;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  // raw pin is counted, so sync lag only makes the count larger
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      hi_cnt <= 8'h00;
      t_cnt <= 8'h00;
    end else begin
      hi_cnt <= !i_chain_reset ? 8'h00 : (hi_cnt == 8'hFF ? hi_cnt : hi_cnt + 8'h01);
      t_cnt <= (o_state != 3'h3) ? 8'h00 : (t_cnt == 8'hFF ? t_cnt : t_cnt + 8'h01);
    end
  end
  sequence s_left_normal;
    o_state == 3'h5 ##1 o_state == 3'h0;
  endsequence
  sequence s_teach_done;
    o_state == 3'h3 ##1 o_state == 3'h4;
  endsequence
  chk_chain_hold: assert property (
    s_left_normal |-> hi_cnt >= RST_HOLD_CYC) else $error("restart on short chain pulse");
  chk_init_off: assert property (
    o_state == 3'h1 |-> !o_safe_output_one && !o_safe_output_two) else $error("output on in init");
  chk_teach_off: assert property (
    o_state inside {3'h2, 3'h3, 3'h4} |-> !o_safe_output_one && !o_safe_output_two)
    else $error("output on during teach-in");
  chk_safe_normal: assert property (
    o_safe_output_one || o_safe_output_two |-> o_state == 3'h5 || $past(o_state) == 3'h5)
    else $error("output on outside normal");
  chk_ready_hold: assert property (
    o_state == 3'h2 && !i_nv_active_valid && !i_code_valid && !$past(i_code_valid)
    && !i_chain_reset |=> o_state == 3'h2) else $error("blank switch left readiness");
  chk_ready_window: assert property (
    o_state == 3'h2 && i_nv_active_valid |-> ##[0:RMAX] o_state != 3'h2)
    else $error("readiness window too long");
  chk_teach_time: assert property (
    s_teach_done |-> t_cnt >= TEACH_CYC - 1 && t_cnt <= TEACH_CYC + 2)
    else $error("teach length off");
  chk_done_alt: assert property (
    (o_state == 3'h4) [*2] |-> o_status_lamp != o_diagnostic_lamp)
    else $error("lamps not alternating");
  chk_abort_diag: assert property (
    (o_state == 3'h6) [*2] |-> o_diagnostic_lamp && !o_safe_output_one)
    else $error("teach error display wrong");
  chk_block_diag: assert property (
    (o_state == 3'h7) [*2] |-> o_diagnostic_lamp && !o_safe_output_two)
    else $error("blocked error display wrong");
endmodule // atic_teach_ctrl_assertions

//--- verif/atic_teach_ctrl_tb.sv
// Purpose: self-checking bench of the teach-in controller
// Assumes: shortened counts; code store image kept by the partner model
// Notes: compares sample at the falling edge, inputs change at the rising edge
`timescale 1ns/1ps
module atic_teach_ctrl_tb;
  localparam [31:0] CA = 32'h1111AAAA;
  localparam [31:0] CB = 32'h2222BBBB;
  localparam [31:0] CC = 32'h3333CCCC;
  // shortened counts so the whole run fits in a few hundred cycles
  localparam [39:0] T_HOLD = 40'h14;
  localparam [39:0] T_INIT = 40'hA;
  localparam [39:0] T_READY = 40'h32;
  localparam [39:0] T_TEACH = 40'h1E;
  localparam [39:0] T_FAST = 40'h2;
  localparam [39:0] T_SLOW = 40'h4;
  localparam [39:0] T_BURST = 40'h2;
  reg i_core_clk = 1'b0;
  reg i_nrst = 1'b0;
  reg chain = 1'b0;
  reg lock = 1'b1;
  reg en1 = 1'b1;
  reg en2 = 1'b1;
  reg cv = 1'b0;
  reg [31:0] code = 32'h00000000;
  reg [36:0] rows [0:4];
  reg stat_q = 1'b0;
  integer rises = 0;
  integer init_rises = 0;
  integer teach_rises = 0;
  integer fail_count = 0;
  integer tests_run = 0;
  integer cyc = 0;
  integer i;
  wire [99:0] rimg;
  wire [99:0] wimg;
  wire wr;
  wire safe1;
  wire safe2;
  wire stat;
  wire diag;
  wire lockd;
  wire [2:0] st;
  atic_nv_store u_store (.i_core_clk(i_core_clk), .i_wr(wr), .i_img(wimg), .o_img(rimg));
  atic_teach_ctrl #(.RST_HOLD_CYC(T_HOLD), .INIT_CYC(T_INIT), .READY_CYC(T_READY),
    .TEACH_CYC(T_TEACH), .FAST_HALF_CYC(T_FAST), .SLOW_HALF_CYC(T_SLOW),
    .BURST_HALF_CYC(T_BURST)) dut (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_chain_reset(chain), .i_lock_input(lock),
    .i_enable_one(en1), .i_enable_two(en2), .i_code_valid(cv), .i_actuator_code(code),
    .i_nv_active_valid(rimg[99]), .i_nv_active_code(rimg[98:67]),
    .i_nv_blocked_valid(rimg[66]), .i_nv_blocked_code(rimg[65:34]),
    .i_nv_pending_valid(rimg[33]), .i_nv_pending_code(rimg[32:1]), .i_nv_busy(rimg[0]),
    .o_safe_output_one(safe1), .o_safe_output_two(safe2), .o_status_lamp(stat),
    .o_diagnostic_lamp(diag), .o_lock_drive(lockd), .o_state(st), .o_nv_wr(wr),
    .o_nv_active_valid(wimg[99]), .o_nv_active_code(wimg[98:67]),
    .o_nv_blocked_valid(wimg[66]), .o_nv_blocked_code(wimg[65:34]),
    .o_nv_pending_valid(wimg[33]), .o_nv_pending_code(wimg[32:1]), .o_nv_busy(wimg[0]));
  always #2.5 i_core_clk = ~i_core_clk;
  // status flashes counted per state to see the lamp is alive in init, ready and teach
  always @(posedge i_core_clk) begin
    stat_q <= stat;
    if (st === 3'h2 && stat === 1'b1 && stat_q === 1'b0) rises <= rises + 1;
    if (st === 3'h1 && stat === 1'b1 && stat_q === 1'b0) init_rises <= init_rises + 1;
    if (st === 3'h3 && stat === 1'b1 && stat_q === 1'b0) teach_rises <= teach_rises + 1;
  end
  // hang guard, well above the few hundred cycles the run needs
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count = fail_count + 1;
      stop_test;
    end
  end
  task stop_test;
    $display("fails=%0d checks=%0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task report(input logic [31:0] g, input logic [31:0] e);
    fail_count = fail_count + 1;
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
  endtask
  task chk_bit(input logic g, input logic e);
    tests_run = tests_run + 1;
    if (g !== e) report(g, e);
  endtask
  task chk_st(input logic [2:0] g, input logic [2:0] e);
    tests_run = tests_run + 1;
    if (g !== e) report(g, e);
  endtask
  task chk_code(input logic [31:0] g, input logic [31:0] e);
    tests_run = tests_run + 1;
    if (g !== e) report(g, e);
  endtask
  task look(input integer n);
    repeat (n) @(posedge i_core_clk);
    @(negedge i_core_clk);
  endtask
  task wait_st(input logic [2:0] s, input integer n);
    integer k;
    k = 0;
    @(negedge i_core_clk);
    while (st !== s && k < n) begin
      @(negedge i_core_clk);
      k = k + 1;
    end
    chk_st(st, s);
  endtask
  // chain reset pulse; the bench stands for a chain of one switch
  task pulse(input integer n);
    @(posedge i_core_clk);
    chain <= 1'b1;
    repeat (n) @(posedge i_core_clk);
    chain <= 1'b0;
  endtask
  task pwr;
    @(posedge i_core_clk);
    i_nrst <= 1'b0;
    repeat (5) @(posedge i_core_clk);
    i_nrst <= 1'b1;
  endtask
  // main sequence: blank switch, first teach, chain teach, table, errors
  initial begin
    rows[0] = {1'b1, CB, 3'h7, 1'b1};
    rows[1] = {1'b1, CA, 3'h7, 1'b0};
    rows[2] = {1'b1, CB, 3'h3, 1'b0};
    rows[3] = {1'b1, CB, 3'h4, 1'b0};
    rows[4] = {1'b0, CB, 3'h7, 1'b0};
    repeat (20) @(posedge i_core_clk);
    chk_st(st, 3'h0);
    i_nrst <= 1'b1;
    wait_st(3'h1, 4);
    chk_bit(safe1, 1'b0);
    wait_st(3'h2, 20);
    chk_bit(init_rises != 0, 1'b1);
    look(100);
    chk_st(st, 3'h2);
    chk_bit(rises != 0, 1'b1);
    @(posedge i_core_clk);
    cv <= 1'b1;
    code <= CA;
    wait_st(3'h3, 4);
    look(3);
    chk_bit(rimg[0], 1'b1);
    chk_bit(safe1, 1'b0);
    wait_st(3'h4, 40);
    chk_bit(teach_rises != 0, 1'b1);
    chk_bit(rimg[99], 1'b0);
    chk_code(rimg[32:1], CA);
    pwr;
    wait_st(3'h5, 40);
    chk_code(rimg[98:67], CA);
    @(posedge i_core_clk);
    code <= CB;
    pulse(15);
    look(10);
    chk_st(st, 3'h5);
    pulse(30);
    wait_st(3'h3, 60);
    wait_st(3'h4, 40);
    pulse(30);
    wait_st(3'h5, 80);
    chk_code(rimg[98:67], CB);
    chk_code(rimg[65:34], CA);
    for (i = 0; i < 5; i = i + 1) begin
      @(posedge i_core_clk);
      cv <= rows[i][36];
      code <= rows[i][35:4];
      lock <= rows[i][3];
      en1 <= rows[i][2];
      en2 <= rows[i][1];
      look(6);
      chk_bit(safe1, rows[i][0]);
      chk_bit(safe2, rows[i][0]);
      chk_bit(lockd, rows[i][3]);
    end
    pulse(30);
    wait_st(3'h2, 60);
    @(posedge i_core_clk);
    cv <= 1'b1;
    code <= CA;
    wait_st(3'h7, 5);
    look(3);
    chk_bit(diag, 1'b1);
    chk_code(rimg[98:67], CB);
    @(posedge i_core_clk);
    cv <= 1'b0;
    pwr;
    wait_st(3'h2, 40);
    @(posedge i_core_clk);
    cv <= 1'b1;
    code <= CC;
    wait_st(3'h3, 4);
    look(5);
    @(posedge i_core_clk);
    cv <= 1'b0;
    wait_st(3'h6, 6);
    look(3);
    chk_bit(rimg[33], 1'b0);
    chk_bit(diag, 1'b1);
    // supply lost mid-teach: the busy mark in the store must lead to the error state
    pwr;
    wait_st(3'h2, 40);
    @(posedge i_core_clk);
    cv <= 1'b1;
    wait_st(3'h3, 4);
    pwr;
    wait_st(3'h6, 20);
    chk_bit(diag, 1'b1);
    chk_code(rimg[98:67], CB);
    @(posedge i_core_clk);
    cv <= 1'b0;
    pwr;
    wait_st(3'h2, 40);
    look(30);
    chk_st(st, 3'h2);
    wait_st(3'h5, 40);
    chk_code(rimg[98:67], CB);
    stop_test;
  end
endmodule // atic_teach_ctrl_tb
bind atic_teach_ctrl atic_teach_ctrl_assertions #(.RST_HOLD_CYC(RST_HOLD_CYC),
  .READY_CYC(READY_CYC), .TEACH_CYC(TEACH_CYC)) u_chk (
  .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_chain_reset(i_chain_reset),
  .i_code_valid(i_code_valid), .i_nv_active_valid(i_nv_active_valid),
  .o_safe_output_one(o_safe_output_one), .o_safe_output_two(o_safe_output_two),
  .o_status_lamp(o_status_lamp), .o_diagnostic_lamp(o_diagnostic_lamp), .o_state(o_state));
